// ### rtl/abmp_host.sv
// Functional notes
// R1: Select low at least 70 ns, then high 60 ns; cycle at least 130 ns.
// R2: Read data is valid no later than 70 ns after select falls.
// R3: Read data is valid 12 ns after gate falls, once select latency passed.
// R4: Device floats data within 15 ns after select rises.
// R5: Device floats data within 15 ns after gate rises.
// R6: Write strobe stays low at least 40 ns.
// R7: Select stays low at least 70 ns before strobe rises.
// R8: Device floats data within 15 ns after strobe falls.
// R9: Device redrives data no sooner than 10 ns after strobe rises.
// R10: Address latched on select fall; strobe low there starts a write.
// R11: Gate drives only the data outputs, not the access type.
// R12: Write ends by select or strobe; order alone decides which.
// R13: Select high is standby; low with strobe high reads; strobe toggling writes.
`timescale 1ns/10ps
`default_nettype none
module abmp_host
(
    input  wire logic                        clk,
    input  wire logic                        reset,
    input  wire logic                        req_valid,
    input  wire logic                        req_write,
    input  wire logic [abmp_pkg::ADDR_W-1:0] req_addr,
    input  wire logic [abmp_pkg::DATA_W-1:0] req_wdata,
    output logic                             req_ready,
    output logic                             rsp_valid,
    output logic      [abmp_pkg::DATA_W-1:0] rsp_rdata,
    output logic                             mem_select_n,
    output logic                             mem_strobe_n,
    output logic                             mem_gate_n,
    output logic      [abmp_pkg::ADDR_W-1:0] mem_addr,
    output logic      [abmp_pkg::DATA_W-1:0] mem_dq_out,
    output logic                             mem_dq_oe,
    input  wire logic [abmp_pkg::DATA_W-1:0] mem_dq_in
);
    import abmp_pkg::*;

    abmp_state_type   state;
    abmp_state_type   next_state;
    logic [DATA_W-1:0] dq_meta;
    logic [DATA_W-1:0] dq_sync;
    logic [CNT_W-1:0]  period;
    logic [CNT_W-1:0]  strobe_cnt;
    logic              wait_done;
    logic              cycle_done;
    logic              take;

    abmp_timer_if tif ();

    abmp_timer abmp_timer_i (
        .clk   (clk),
        .reset (reset),
        .tif   (tif)
    );

    // Request handshake and cycle-length guard
    assign take       = req_valid && req_ready;
    assign wait_done  = tif.done;
    assign cycle_done = (period >= CNT_W'(PERIOD_CYC));

    // Next state of the bus sequencer
    always_comb
    begin
        next_state = state;
        case (state)
            ABMP_IDLE:
                if (take)
                    next_state = req_write ? ABMP_WSEL : ABMP_RSEL;
            ABMP_RSEL:
                if (wait_done)
                    next_state = ABMP_RFLT;
            ABMP_RFLT:
                if (wait_done)
                    next_state = ABMP_PRECH;
            ABMP_WSEL:
                if (wait_done)
                    next_state = ABMP_WEND;
            ABMP_WEND:
                if (wait_done)
                    next_state = ABMP_PRECH;
            ABMP_PRECH:
                if (wait_done && cycle_done)
                    next_state = ABMP_IDLE;
            default:
                next_state = ABMP_IDLE;
        endcase
    end

    // Timer loads on each phase change
    assign tif.load  = (next_state != state);
    assign tif.value = (next_state == ABMP_RSEL)  ? CNT_W'(READ_CYC + SYNC_CYC) :
                       (next_state == ABMP_RFLT)  ? CNT_W'(FLOAT_CYC) :
                       (next_state == ABMP_WSEL)  ? CNT_W'(ACTIVE_CYC) :
                       (next_state == ABMP_WEND)  ? CNT_W'(HOLD_CYC) :
                       (next_state == ABMP_PRECH) ? CNT_W'(PRECH_CYC) : 4'h0;

    // Pin input synchroniser, two stages
    always_ff @(posedge clk)
    begin
        dq_meta <= mem_dq_in;
        dq_sync <= dq_meta;
    end

    // Sequencer state and cycle length counter
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            state  <= ABMP_IDLE;
            period <= 4'h0;
        end
        else
        begin
            state  <= next_state;
            if (take)
                period <= 4'h1;
            else if (period != 4'hF)
                period <= period + 4'h1;
        end
    end

    // Select and strobe pins; strobe falls with select so write starts at latch
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            mem_select_n <= 1'b1;
            mem_strobe_n <= 1'b1;
        end
        else
        begin
            mem_select_n <= !(next_state == ABMP_RSEL || next_state == ABMP_WSEL); // R1 R13
            mem_strobe_n <= !(next_state == ABMP_WSEL);                            // R6 R7 R12
        end
    end

    // Gate opens only for reads; it does not pick the access type
    always_ff @(posedge clk)
    begin
        if (reset)
            mem_gate_n <= 1'b1;
        else
            mem_gate_n <= !(next_state == ABMP_RSEL); // R11
    end

    // Address and write data; data driven only while strobe is low
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            mem_addr   <= '0;
            mem_dq_out <= '0;
            mem_dq_oe  <= 1'b0;
        end
        else
        begin
            if (take)
            begin
                mem_addr   <= req_addr;   // R10
                mem_dq_out <= req_wdata;
            end
            mem_dq_oe <= (next_state == ABMP_WSEL); // R8 R9
        end
    end

    // Handshake outputs and read capture after access latency
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            req_ready <= 1'b0;
            rsp_valid <= 1'b0;
            rsp_rdata <= '0;
        end
        else
        begin
            req_ready <= (next_state == ABMP_IDLE) && !take;
            rsp_valid <= (state == ABMP_RSEL) && wait_done; // R2 R3
            if ((state == ABMP_RSEL) && wait_done)
                rsp_rdata <= dq_sync;
        end
    end

    // Select low time covers the least active time
    a_select_active: assert property (@(posedge clk) disable iff (reset) // R1
        $fell(mem_select_n) |-> !mem_select_n [*4])
        else $error("select released too early");

    // Precharge between accesses
    a_precharge_min: assert property (@(posedge clk) disable iff (reset) // R1
        $rose(mem_select_n) |-> mem_select_n [*3])
        else $error("precharge too short");

    // Strobe pulse width
    a_strobe_width: assert property (@(posedge clk) disable iff (reset) // R6
        $fell(mem_strobe_n) |-> !mem_strobe_n [*2])
        else $error("strobe pulse too short");

    // Select low one and four cycles before the strobe's rise
    a_select_strobe: assert property (@(posedge clk) disable iff (reset) // R7
        $rose(mem_strobe_n) |-> !$past(mem_select_n) && !$past(mem_select_n, 4))
        else $error("select not held before strobe end");

    // Host drives data only with strobe low
    a_drive_strobe: assert property (@(posedge clk) disable iff (reset) // R8
        mem_dq_oe |-> !mem_strobe_n && mem_gate_n)
        else $error("data driven outside strobe");

    // No host drive right after strobe ends, leaving room for device redrive
    a_redrive_gap: assert property (@(posedge clk) disable iff (reset) // R9
        $rose(mem_strobe_n) |-> !mem_dq_oe)
        else $error("host drive after strobe end");

    // Read sample waits past both access latencies
    a_read_sample: assert property (@(posedge clk) disable iff (reset) // R2
        rsp_valid |-> !$past(mem_select_n, 5) && !$past(mem_gate_n, 2))
        else $error("read sampled too early");

    // Gate never low during a write
    a_gate_read: assert property (@(posedge clk) disable iff (reset) // R11
        !mem_strobe_n |-> mem_gate_n)
        else $error("gate open in write");

    // Float wait after read before next drive
    a_float_gap: assert property (@(posedge clk) disable iff (reset) // R5
        $rose(mem_gate_n) |-> !mem_dq_oe [*2])
        else $error("drive before device floats");

    // Strobe falls together with select
    a_write_latch: assert property (@(posedge clk) disable iff (reset) // R10
        $fell(mem_strobe_n) |-> $fell(mem_select_n))
        else $error("strobe not low at select fall");
endmodule
`default_nettype wire

// ### include/abmp_pkg.sv
package abmp_pkg;
    // Memory geometry
    localparam int ADDR_W = 15;
    localparam int DATA_W = 8;
    // Clock period in ps (50 MHz)
    localparam int CLK_PS = 20000;
    // Host-side timing figures in ns
    localparam int MIN_SELECT_ACTIVE_NS        = 70;
    localparam int MIN_PRECHARGE_NS            = 60;
    localparam int MIN_READ_PERIOD_NS          = 130;
    localparam int SELECT_TO_DATA_DELAY_NS     = 70;
    localparam int GATE_TO_DATA_DELAY_NS       = 12;
    localparam int DESELECT_FLOAT_DELAY_NS     = 15;
    localparam int GATE_OFF_FLOAT_DELAY_NS     = 15;
    localparam int MIN_STROBE_WIDTH_NS         = 40;
    localparam int SELECT_BEFORE_STROBE_END_NS = 70;
    localparam int STROBE_LOW_FLOAT_DELAY_NS   = 15;
    localparam int STROBE_HIGH_REDRIVE_DELAY_NS = 10;
    localparam int DATA_SETUP_NS               = 30;
    localparam int ADDR_HOLD_NS                = 15;

    // Least time in cycles, rounded up, at least one
    function automatic int ns_to_cyc(input int ns);
        int c;
        c = (ns * 1000 + CLK_PS - 1) / CLK_PS;
        return (c < 1) ? 1 : c;
    endfunction

    localparam int ACTIVE_CYC   = ns_to_cyc(MIN_SELECT_ACTIVE_NS);
    localparam int PRECH_CYC    = ns_to_cyc(MIN_PRECHARGE_NS);
    localparam int PERIOD_CYC   = ns_to_cyc(MIN_READ_PERIOD_NS);
    // Read sample: select latency plus gate latency; the host adds the synchroniser stages
    localparam int READ_CYC     = ns_to_cyc(SELECT_TO_DATA_DELAY_NS
                                            + GATE_TO_DATA_DELAY_NS);
    // Synchroniser stages on the data pins
    localparam int SYNC_CYC     = 2;
    localparam int FLOAT_CYC    = ns_to_cyc(GATE_OFF_FLOAT_DELAY_NS
                                            + DESELECT_FLOAT_DELAY_NS);
    localparam int STROBE_CYC   = ns_to_cyc(MIN_STROBE_WIDTH_NS);
    localparam int WFLOAT_CYC   = ns_to_cyc(STROBE_LOW_FLOAT_DELAY_NS);
    localparam int WSETUP_CYC   = ns_to_cyc(DATA_SETUP_NS);
    localparam int HOLD_CYC     = ns_to_cyc(ADDR_HOLD_NS);
    localparam int CNT_W        = 4;

    typedef enum logic [2:0] {
        ABMP_IDLE  = 3'b000,
        ABMP_RSEL  = 3'b001,
        ABMP_RFLT  = 3'b011,
        ABMP_WSEL  = 3'b101,
        ABMP_WEND  = 3'b111,
        ABMP_PRECH = 3'b010
    } abmp_state_type;
endpackage

// ### include/abmp_timer_if.sv
`timescale 1ns/10ps
`default_nettype none
// Countdown load and done between the sequencer and its timer
interface abmp_timer_if;
    import abmp_pkg::*;
    logic             load;
    logic [CNT_W-1:0] value;
    logic             done;
    modport ctrl  (output load, output value, input done);
    modport timer (input load, input value, output done);
endinterface
`default_nettype wire

// ### rtl/abmp_timer.sv
`timescale 1ns/10ps
`default_nettype none
module abmp_timer
(
    input  wire logic   clk,
    input  wire logic   reset,
    abmp_timer_if.timer tif
);
    import abmp_pkg::*;

    logic [CNT_W-1:0] count;

    // Done while the count rests at zero; load depends on done, so it stays out
    assign tif.done = (count == 4'h0);

    // Load wins over counting down
    always_ff @(posedge clk)
    begin
        if (reset)
            count <= 4'h0;
        else if (tif.load)
            count <= tif.value;
        else if (count != 4'h0)
            count <= count - 4'h1;
    end
endmodule
`default_nettype wire

// ### verif/abmp_mem_model.sv
`timescale 1ns/10ps
`default_nettype none
// Byte-wide memory at worst-case pin timing; viol counts host timing faults
module abmp_mem_model
(
    input  wire logic [abmp_pkg::ADDR_W-1:0] addr,
    input  wire logic                        select_n,
    input  wire logic                        strobe_n,
    input  wire logic                        gate_n,
    input  wire logic [abmp_pkg::DATA_W-1:0] host_dq,
    input  wire logic                        host_oe,
    output logic      [abmp_pkg::DATA_W-1:0] dq_level,
    output logic      [7:0]                  viol
);
    import abmp_pkg::*;
    logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];
    logic [ADDR_W-1:0] lat_addr = '0;
    logic [DATA_W-1:0] last = '0;
    logic              sel_ok = 0, gate_ok = 0, stb_ok = 1, is_wr = 0;
    realtime           t_fall = -1000, t_rise = -1000, t_sfall = 0;
    wire               drv = sel_ok && gate_ok && stb_ok && !is_wr;
    wire               contend = host_oe && drv;
    wire [DATA_W-1:0]  dq_d;
    // Preset contents and clear fault count
    initial
    begin
        viol = '0;
        for (int i = 0; i < (1<<ADDR_W); i++)
            mem[i] = i[7:0] ^ 8'hA5;
    end
    // Drive windows: latest valid, latest float, earliest redrive
    always @(select_n) sel_ok <= #(select_n ? 15 : 70) !select_n;
    always @(gate_n) gate_ok <= #(gate_n ? 15 : 12) !gate_n;
    always @(strobe_n) stb_ok <= #(strobe_n ? 10 : 15) strobe_n;
    // Latch address and decode access on select fall
    always @(negedge select_n)
    begin
        if ($realtime - t_rise < MIN_PRECHARGE_NS || $realtime - t_fall < MIN_READ_PERIOD_NS)
            viol++;
        t_fall = $realtime;
        #1;
        lat_addr = addr;
        is_wr = !strobe_n;
    end
    // Strobe falling inside a select window makes it a write
    always @(negedge strobe_n)
    begin
        t_sfall = $realtime;
        if (!select_n)
            is_wr = 1'b1;
    end
    // Select high time begins
    always @(posedge select_n)
    begin
        if ($realtime - t_fall < MIN_SELECT_ACTIVE_NS)
            viol++;
        t_rise = $realtime;
    end
    // Write ends on whichever of strobe or select rises first
    always @(posedge strobe_n or posedge select_n)
    begin
        if (is_wr)
        begin
            if ($realtime - t_sfall < MIN_STROBE_WIDTH_NS
                || $realtime - t_fall < SELECT_BEFORE_STROBE_END_NS)
                viol++;
            mem[lat_addr] = dq_d;
            is_wr = 1'b0;
        end
    end
    // Both parties driving at once is a fault
    always @(posedge contend) viol++;
    // Undriven pins show the inverse of the last driven level
    always @* if (host_oe || drv) last = host_oe ? host_dq : mem[lat_addr];
    assign dq_level = host_oe ? host_dq : (drv ? mem[lat_addr] : ~last);
    assign #1 dq_d = dq_level;
endmodule
`default_nettype wire

// ### verif/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
// Host controller driven at its user port against the memory model
module tb_top;
    import abmp_pkg::*;
    logic              clk = 0, reset = 1, req_valid = 0, req_write = 0;
    logic [ADDR_W-1:0] req_addr = '0, mem_addr;
    logic [DATA_W-1:0] req_wdata = '0, rsp_rdata, mem_dq_out, mem_dq_in, q;
    logic              req_ready, rsp_valid, mem_select_n, mem_strobe_n, mem_gate_n, mem_dq_oe;
    logic [7:0]        viol;
    int                miscompares = 0, n_checks = 0;
    abmp_host abmp_host_i (.clk(clk), .reset(reset), .req_valid(req_valid),
        .req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata),
        .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
        .mem_select_n(mem_select_n), .mem_strobe_n(mem_strobe_n), .mem_gate_n(mem_gate_n),
        .mem_addr(mem_addr), .mem_dq_out(mem_dq_out), .mem_dq_oe(mem_dq_oe),
        .mem_dq_in(mem_dq_in));
    abmp_mem_model abmp_mem_model_i (.addr(mem_addr), .select_n(mem_select_n),
        .strobe_n(mem_strobe_n), .gate_n(mem_gate_n), .host_dq(mem_dq_out),
        .host_oe(mem_dq_oe), .dq_level(mem_dq_in), .viol(viol));
    // Clock
    initial forever #10 clk = ~clk;
    // Compare one value
    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_checks++;
        if (got !== exp)
        begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask
    // Counts and verdict
    task automatic summarize();
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // One request; read data returned in q
    task automatic access(input logic wr, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        int n;
        n = 0;
        while (req_ready !== 1'b1 && n < 60)
        begin
            @(posedge clk);
            #1;
            n++;
        end
        check("req_ready", 1, req_ready);
        {req_valid, req_write, req_addr, req_wdata} = {1'b1, wr, a, d};
        @(posedge clk);
        #1;
        req_valid = 0;
        n = 0;
        while (!wr && rsp_valid !== 1'b1 && n < 30)
        begin
            @(posedge clk);
            #1;
            n++;
        end
        if (!wr)
            check("rsp_valid", 1, rsp_valid);
        q = rsp_rdata;
    endtask
    // Pins idle in standby after reset
    task automatic t_reset();
        check("idle pins", 4'hE, {mem_select_n, mem_strobe_n, mem_gate_n, mem_dq_oe});
        $display("test reset done");
    endtask
    // Preset contents read at both ends of the address range
    task automatic t_preload();
        logic [ADDR_W-1:0] al [3] = '{15'h0000, 15'h7FFF, 15'h1234};
        foreach (al[i])
        begin
            access(0, al[i], 8'h00);
            check("preload read", al[i][7:0] ^ 8'hA5, q);
        end
        $display("test preload done");
    endtask
    // Back-to-back writes, then read back
    task automatic t_write_read();
        logic [ADDR_W-1:0] al [3] = '{15'h0001, 15'h7FFE, 15'h4000};
        logic [DATA_W-1:0] dl [3] = '{8'hFF, 8'h00, 8'h3C};
        foreach (al[i])
            access(1, al[i], dl[i]);
        foreach (al[i])
        begin
            access(0, al[i], 8'h00);
            check("write readback", dl[i], q);
        end
        $display("test write_read done");
    endtask
    // Overwrite one byte; neighbour untouched
    task automatic t_overwrite();
        access(1, 15'h0055, 8'h11);
        access(1, 15'h0055, 8'hEE);
        access(0, 15'h0055, 8'h00);
        check("overwrite", 8'hEE, q);
        access(0, 15'h0056, 8'h00);
        check("neighbour", 8'h56 ^ 8'hA5, q);
        $display("test overwrite done");
    endtask
    // Main sequence
    initial
    begin
        repeat (6) @(posedge clk);
        #1;
        reset = 0;
        t_reset();
        t_preload();
        t_write_read();
        t_overwrite();
        repeat (10) @(posedge clk);
        check("host timing faults", 0, viol);
        summarize();
    end
    // Watchdog
    initial
    begin
        #200000;
        miscompares++;
        summarize();
    end
endmodule
`default_nettype wire
